// *** core/fspr_pin_roles.v ***
// Pin direction, pause, reset, write-guard and boost logic of a serial flash
//
// How it works
// - Line zero input bits are latched on rising serial clock edges.
// - Dual/quad output and I/O reads drive line zero on falling edges.
// - Line one shifts out on falling edges; dual/quad programs latch it rising.
// - Two-line protocol: lines zero and one are bidirectional in every phase.
// - Four-line: lines bidirectional, except boost program/erase falls back until boost low.
// - Write-guard pin is line two in four-line protocol and quad reads.
// - Input receivers stay enabled on every line unless it is driven.
// - Pause pin is line three in quad roles; pause ignored then, reset only if deselected in four-line.
// - Reset pin low forces reset mode and releases all outputs.
// - Pause low suspends transfer: line one released, line zero and clock ignored.
// - Pause disabled by bit 4 of persistent or volatile config register.
// - Recognised double transfer rate operation disables pause at once.
// - Four-line, deselected: shared pause pin resets device unless disabled.
// - Extended single/dual: write-guard low blocks program/erase in protected region.
// - Boost acceleration only when volatile config bit 3 is zero; default disabled.
// - Enabled boost pin is data until the last data input; no boost in 200 ms: standard speed.
// - Select high deselects and releases line one; low activates.
`include "fspr_regs.vh"
`default_nettype none

module fspr_pin_roles #(
	parameter BOOST_WAIT_CYC = `FSPR_BOOST_WAIT_CYC
) (
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	// Pins from outside, synchronised here
	input wire sclk_i,
	input wire sel_n_i,
	input wire hw_reset_n_i,
	input wire boost_high_i,
	input wire serial_line_zero_i,
	input wire serial_line_one_i,
	input wire serial_line_two_i,
	input wire serial_line_three_i,
	output reg serial_line_zero_o,
	output reg serial_line_zero_oe_o,
	output reg serial_line_one_o,
	output reg serial_line_one_oe_o,
	output reg serial_line_two_o,
	output reg serial_line_two_oe_o,
	output reg serial_line_three_o,
	output reg serial_line_three_oe_o,
	// Core side, same clock
	input wire [1:0] proto_i,
	input wire [2:0] cmd_class_i,
	input wire data_out_phase_i,
	input wire [3:0] tx_bits_i,
	input wire dtr_seen_i,
	input wire modify_op_i,
	input wire last_data_i,
	input wire op_done_i,
	input wire [7:0] persistent_config_reg_i,
	input wire volatile_enh_config_reg_wr_i,
	input wire [7:0] volatile_enh_config_reg_wdata_i,
	input wire pause_reset_dis_i,
	input wire reset_capable_i,
	output reg [3:0] rx_bits_o,
	output reg rx_valid_o,
	output reg rx_four_o,
	output reg in_reset_o,
	output reg paused_o,
	output reg write_blocked_o,
	output reg boost_active_o,
	output reg boost_fast_o,
	output reg [1:0] eff_proto_o,
	output reg [7:0] volatile_enh_config_reg_o
);

	localparam [31:0] BOOST_WAIT = BOOST_WAIT_CYC;
	localparam [2:0] BST_IDLE = 3'h1;
	localparam [2:0] BST_WAIT = 3'h2;
	localparam [2:0] BST_RUN = 3'h4;

	////////////////////////////////////////////////////////////////////////
	// Two-flop synchronisers for all pin inputs
	wire [8:0] raw_w;
	reg [8:0] sync1_q;
	reg [8:0] sync2_q;
	assign raw_w = {serial_line_three_i, serial_line_two_i, serial_line_one_i,
		serial_line_zero_i, boost_high_i, hw_reset_n_i, sel_n_i, sclk_i, 1'b0};

	genvar gi;
	generate
		for (gi = 0; gi < 9; gi = gi + 1) begin : g_sync
			// Resets pick the idle level: select high, reset pin high
			always @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					sync1_q[gi] <= (gi == 2 || gi == 3) ? 1'b1 : 1'b0;
					sync2_q[gi] <= (gi == 2 || gi == 3) ? 1'b1 : 1'b0;
				end else if (ce_i) begin
					sync1_q[gi] <= raw_w[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate

	wire sclk_s = sync2_q[1];
	wire sel_n_s = sync2_q[2];
	wire rst_pin_n_s = sync2_q[3];
	wire boost_s = sync2_q[4];
	wire [3:0] lines_s = sync2_q[8:5];

	////////////////////////////////////////////////////////////////////////
	// Edge detection on the sampled serial clock
	reg sclk_prev_q;
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sclk_prev_q <= 1'b0;
		end else if (ce_i) begin
			sclk_prev_q <= sclk_s;
		end
	end
	wire rise_w = sclk_s & ~sclk_prev_q;
	wire fall_w = ~sclk_s & sclk_prev_q;

	////////////////////////////////////////////////////////////////////////
	// Role decode
	reg boost_fallback_q;
	reg dtr_latch_q;
	wire [1:0] eff_proto_w = boost_fallback_q ? `FSPR_PROTO_EXT : proto_i;
	wire four_w = (eff_proto_w == `FSPR_PROTO_FOUR);
	wire two_w = (eff_proto_w == `FSPR_PROTO_TWO);
	wire quad_rd_w = (cmd_class_i == `FSPR_CMD_QUAD_OUT_RD) ||
		(cmd_class_i == `FSPR_CMD_QUAD_IO_RD);
	wire multi_rd_w = quad_rd_w || (cmd_class_i == `FSPR_CMD_DUAL_OUT_RD) ||
		(cmd_class_i == `FSPR_CMD_DUAL_IO_RD);
	wire multi_prog_w = (cmd_class_i == `FSPR_CMD_DUAL_IN_PROG) ||
		(cmd_class_i == `FSPR_CMD_QUAD_IN_PROG);
	// Quad role of the write-guard and pause pins
	wire quad_role_w = four_w || quad_rd_w;
	// Line zero drivable in multi-line reads or two/four-line protocols
	wire l0_bidir_w = multi_rd_w || two_w || four_w;
	// Line one stays an output except in multi-line programs
	wire l1_input_w = multi_prog_w && data_out_phase_i == 1'b0;
	// A zero in either register turns pause off; ones (erased state) keep it on
	wire pause_cfg_dis_w = ~persistent_config_reg_i[`FSPR_CFG_PAUSE_DIS_BIT] |
		~volatile_enh_config_reg_o[`FSPR_CFG_PAUSE_DIS_BIT];
	// Pause only counts while selected and not in a quad role
	wire pause_w = ~sel_n_s & ~lines_s[3] & ~quad_role_w & ~pause_cfg_dis_w &
		~dtr_latch_q & ~dtr_seen_i;
	// Reset via pause pin, only when deselected in four-line protocol
	wire pin_reset_w = reset_capable_i & four_w & sel_n_s & ~lines_s[3] &
		~pause_reset_dis_i;
	wire reset_w = ~rst_pin_n_s | pin_reset_w;
	wire active_w = ~sel_n_s & ~reset_w & ~pause_w;

	////////////////////////////////////////////////////////////////////////
	// Double transfer rate latch, cleared at deselect
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dtr_latch_q <= 1'b0;
		end else if (ce_i) begin
			if (dtr_seen_i) begin
				dtr_latch_q <= 1'b1;
			end else if (sel_n_s) begin
				dtr_latch_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Volatile enhanced configuration register
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			volatile_enh_config_reg_o <= `FSPR_VOLATILE_ENH_CONFIG_REG_RESET;
		end else if (ce_i) begin
			if (reset_w) begin
				volatile_enh_config_reg_o <= `FSPR_VOLATILE_ENH_CONFIG_REG_RESET;
			end else if (volatile_enh_config_reg_wr_i) begin
				volatile_enh_config_reg_o <= volatile_enh_config_reg_wdata_i;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Boost supply state machine
	reg [2:0] bst_q;
	reg [31:0] wait_cnt_q;
	wire boost_en_w = ~volatile_enh_config_reg_o[`FSPR_CFG_BOOST_DIS_BIT];
	wire boost_cmd_w = (cmd_class_i == `FSPR_CMD_QUAD_IN_PROG) || (four_w && modify_op_i);
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bst_q <= BST_IDLE;
			wait_cnt_q <= 32'h0;
			boost_fallback_q <= 1'b0;
			boost_fast_o <= 1'b0;
		end else if (ce_i) begin
			if (reset_w) begin
				bst_q <= BST_IDLE;
				boost_fallback_q <= 1'b0;
				boost_fast_o <= 1'b0;
			end else begin
				case (bst_q)
					BST_IDLE: begin
						boost_fast_o <= 1'b0;
						// Op may end before boost drops; fall back until it does
						if (!boost_s) begin
							boost_fallback_q <= 1'b0;
						end
						if (boost_en_w && boost_cmd_w && last_data_i) begin
							bst_q <= BST_WAIT;
							wait_cnt_q <= 32'h0;
						end
					end
					BST_WAIT: begin
						// Boost late: run at standard speed
						if (boost_s) begin
							bst_q <= BST_RUN;
							boost_fast_o <= 1'b1;
							boost_fallback_q <= (proto_i == `FSPR_PROTO_FOUR);
						end else if (wait_cnt_q >= BOOST_WAIT - 32'h1) begin
							bst_q <= BST_IDLE;
						end else begin
							wait_cnt_q <= wait_cnt_q + 32'h1;
						end
					end
					BST_RUN: begin
						if (!boost_s) begin
							boost_fallback_q <= 1'b0;
						end
						if (op_done_i) begin
							bst_q <= BST_IDLE;
							boost_fast_o <= 1'b0;
						end
					end
					default: begin
						bst_q <= BST_IDLE;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive path: rising-edge sampling
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_bits_o <= 4'h0;
			rx_valid_o <= 1'b0;
			rx_four_o <= 1'b0;
		end else if (ce_i) begin
			rx_valid_o <= active_w & rise_w;
			rx_four_o <= quad_role_w;
			if (active_w && rise_w) begin
				// Receivers read all undriven lines
				rx_bits_o <= lines_s & ~{serial_line_three_oe_o, serial_line_two_oe_o,
					serial_line_one_oe_o, serial_line_zero_oe_o};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Drive path: enables follow role, data changes on falling edges
	// Host must have released lines first; the device does not detect contention
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			serial_line_zero_o <= 1'b0;
			serial_line_one_o <= 1'b0;
			serial_line_two_o <= 1'b0;
			serial_line_three_o <= 1'b0;
			serial_line_zero_oe_o <= 1'b0;
			serial_line_one_oe_o <= 1'b0;
			serial_line_two_oe_o <= 1'b0;
			serial_line_three_oe_o <= 1'b0;
		end else if (ce_i) begin
			if (!active_w) begin
				// Deselect, pause and reset all release the pins
				serial_line_zero_oe_o <= 1'b0;
				serial_line_one_oe_o <= 1'b0;
				serial_line_two_oe_o <= 1'b0;
				serial_line_three_oe_o <= 1'b0;
			end else if (fall_w) begin
				serial_line_zero_oe_o <= data_out_phase_i & l0_bidir_w;
				serial_line_one_oe_o <= data_out_phase_i & ~l1_input_w;
				serial_line_two_oe_o <= data_out_phase_i & quad_role_w;
				serial_line_three_oe_o <= data_out_phase_i & quad_role_w;
				serial_line_zero_o <= tx_bits_i[0];
				serial_line_one_o <= tx_bits_i[1];
				serial_line_two_o <= tx_bits_i[2];
				serial_line_three_o <= tx_bits_i[3];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status outputs
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			in_reset_o <= 1'b1;
			paused_o <= 1'b0;
			write_blocked_o <= 1'b0;
			boost_active_o <= 1'b0;
			eff_proto_o <= `FSPR_PROTO_EXT;
		end else if (ce_i) begin
			in_reset_o <= reset_w;
			paused_o <= pause_w;
			// Region check against block-protect bits is done by the core
			write_blocked_o <= (eff_proto_w == `FSPR_PROTO_EXT) & ~quad_rd_w &
				~lines_s[2];
			boost_active_o <= (bst_q != BST_IDLE);
			eff_proto_o <= eff_proto_w;
		end
	end

endmodule // fspr_pin_roles
`default_nettype wire

// *** core/fspr_regs.vh ***
// Constants for the serial flash pin-role block
`ifndef FSPR_REGS_VH
`define FSPR_REGS_VH

// Protocol encodings
`define FSPR_PROTO_EXT 2'h0
`define FSPR_PROTO_TWO 2'h1
`define FSPR_PROTO_FOUR 2'h2

// Command classes, decided by the command decoder outside this block
`define FSPR_CMD_NONE 3'h0
`define FSPR_CMD_DUAL_OUT_RD 3'h1
`define FSPR_CMD_QUAD_OUT_RD 3'h2
`define FSPR_CMD_DUAL_IO_RD 3'h3
`define FSPR_CMD_QUAD_IO_RD 3'h4
`define FSPR_CMD_DUAL_IN_PROG 3'h5
`define FSPR_CMD_QUAD_IN_PROG 3'h6
`define FSPR_CMD_OTHER_MOD 3'h7

// Configuration bit positions
`define FSPR_CFG_PAUSE_DIS_BIT 4
`define FSPR_CFG_BOOST_DIS_BIT 3
`define FSPR_VOLATILE_ENH_CONFIG_REG_RESET 8'hFF

// Boost wait window: 200 ms at a 100 ns clock
`define FSPR_BOOST_WAIT_MS 200
`define FSPR_CLK_NS 100
`define FSPR_BOOST_WAIT_CYC ((`FSPR_BOOST_WAIT_MS * 1000000) / `FSPR_CLK_NS)

`endif

// *** testbench/fspr_asserts.sv ***
// Checker for pin roles, pause, reset and boost of the serial flash block
`include "fspr_regs.vh"
`default_nettype none
module fspr_asserts #(
	parameter int BOOST_WAIT_CYC = 50
) (
	input wire clk_i,
	input wire rst_i,
	input wire sel_n_i,
	input wire hw_reset_n_i,
	input wire [1:0] proto_i,
	input wire [2:0] cmd_class_i,
	input wire dtr_seen_i,
	input wire serial_line_zero_oe_o,
	input wire serial_line_one_oe_o,
	input wire serial_line_two_oe_o,
	input wire serial_line_three_oe_o,
	input wire rx_valid_o,
	input wire in_reset_o,
	input wire paused_o,
	input wire boost_active_o,
	input wire boost_fast_o,
	input wire [1:0] eff_proto_o,
	input wire [7:0] volatile_enh_config_reg_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int wait_q;
	wire any_oe = serial_line_zero_oe_o | serial_line_one_oe_o | serial_line_two_oe_o
		| serial_line_three_oe_o;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////
	// Cycles spent waiting for the boost level; a counter, as the wait is long
	always @(posedge clk_i or posedge rst_i)
		if (rst_i) wait_q <= 0;
		else wait_q <= (boost_active_o && !boost_fast_o) ? wait_q + 1 : 0;
	////////////////////////////////////////////////////////////////
	hw_reset_a: assert property (!hw_reset_n_i [*6] |-> in_reset_o && !any_oe)
		else $error("outputs driven in pin reset");
	deselect_a: assert property (sel_n_i [*6] |-> !serial_line_one_oe_o)
		else $error("line one driven while deselected");
	pause_rel_a: assert property (paused_o [*5] |-> !serial_line_one_oe_o)
		else $error("line one driven while paused");
	boost_en_a: assert property ($rose(boost_active_o) |-> !volatile_enh_config_reg_o[3])
		else $error("boost started while disabled");
	boost_wait_a: assert property (wait_q <= BOOST_WAIT_CYC + 4)
		else $error("boost wait overran its window");
	boost_proto_a: assert property (boost_fast_o [*2] ##0 proto_i == `FSPR_PROTO_FOUR
		|-> eff_proto_o == `FSPR_PROTO_EXT)
		else $error("no fallback during boost");
	dtr_pause_a: assert property (dtr_seen_i |-> ##[1:5] !paused_o)
		else $error("pause kept after double rate");
	quad_pin_a: assert property (serial_line_two_oe_o |-> proto_i == `FSPR_PROTO_FOUR
		|| cmd_class_i inside {`FSPR_CMD_QUAD_OUT_RD, `FSPR_CMD_QUAD_IO_RD})
		else $error("line two driven outside quad role");
	rx_gate_a: assert property (rx_valid_o |-> !in_reset_o && !paused_o)
		else $error("bit taken while blocked");
	cover property (paused_o);
	cover property (boost_fast_o);
	cover property (rx_valid_o);
endmodule // fspr_asserts
bind fspr_pin_roles fspr_asserts #(.BOOST_WAIT_CYC(BOOST_WAIT_CYC)) fspr_asserts_inst (.*);
`default_nettype wire

// *** testbench/fspr_host_model.sv ***
// Host controller model: select, framed serial clock and data lines
`default_nettype none
module fspr_host_model (
	input wire logic clk_i,
	input wire logic frame_i,
	input wire logic [3:0] drv_i,
	input wire logic [3:0] dat_i,
	output var logic sel_n_o,
	output var logic sclk_o,
	output var logic [3:0] line_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] div_q = 2'h0;
	logic [3:0] last_q = 4'h0;
	initial begin
		sel_n_o = 1'b1;
		sclk_o = 1'b0;
		line_o = 4'hF;
	end
	// Clock runs only inside a frame, 800 ns period; select stays low through pauses
	always @(posedge clk_i) begin
		sel_n_o <= #1 !frame_i;
		div_q <= frame_i ? div_q + 2'h1 : 2'h0;
		sclk_o <= #1 frame_i && ((div_q == 2'h3) ? !sclk_o : sclk_o);
	end
	// Released lines show the inverse of the last value, never a stale copy
	always @(posedge clk_i) begin
		line_o <= #1 (drv_i & dat_i) | (~drv_i & ~last_q);
		last_q <= (drv_i & dat_i) | (~drv_i & last_q);
	end
endmodule // fspr_host_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the serial flash pin-role block
`include "fspr_regs.vh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i, rst_i, ce_i, sclk_i, sel_n_i, hw_reset_n_i, boost_high_i, h_frame;
	logic serial_line_zero_i, serial_line_one_i, serial_line_two_i, serial_line_three_i;
	logic serial_line_zero_o, serial_line_one_o, serial_line_two_o, serial_line_three_o;
	logic serial_line_zero_oe_o, serial_line_one_oe_o, serial_line_two_oe_o;
	logic serial_line_three_oe_o, data_out_phase_i, dtr_seen_i, modify_op_i, last_data_i;
	logic op_done_i, volatile_enh_config_reg_wr_i, pause_reset_dis_i, reset_capable_i, rx_valid_o, rx_four_o;
	logic in_reset_o, paused_o, write_blocked_o, boost_active_o, boost_fast_o;
	logic [1:0] proto_i, eff_proto_o;
	logic [2:0] cmd_class_i;
	logic [3:0] tx_bits_i, rx_bits_o, h_drv, h_dat, h_line;
	logic [7:0] persistent_config_reg_i, volatile_enh_config_reg_wdata_i, volatile_enh_config_reg_o;
	int miscompares, samples_checked;
	// Pin level: the device wins while it drives, else the host side
	assign serial_line_zero_i = serial_line_zero_oe_o ? serial_line_zero_o : h_line[0];
	assign serial_line_one_i = serial_line_one_oe_o ? serial_line_one_o : h_line[1];
	assign serial_line_two_i = serial_line_two_oe_o ? serial_line_two_o : h_line[2];
	assign serial_line_three_i = serial_line_three_oe_o ? serial_line_three_o : h_line[3];
	fspr_pin_roles #(.BOOST_WAIT_CYC(50)) fspr_pin_roles_inst (.*);
	fspr_host_model fspr_host_model_inst (.clk_i(clk_i), .frame_i(h_frame), .drv_i(h_drv),
		.dat_i(h_dat), .sel_n_o(sel_n_i), .sclk_o(sclk_i), .line_o(h_line));
	////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#5;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Quad read: bit taken on a rise, then all four lines driven from the fall
	task automatic s_read;
		cmd_class_i = `FSPR_CMD_QUAD_OUT_RD;
		h_drv = 4'hD;
		h_dat = 4'hD;
		h_frame = 1'b1;
		repeat (40) begin
			cyc(1);
			if (rx_valid_o === 1'b1) break;
		end
		chk(rx_valid_o, 8'h01);
		chk(rx_bits_o[0], 8'h01);
		h_drv = 4'h0;
		data_out_phase_i = 1'b1;
		tx_bits_i = 4'hA;
		cyc(12);
		chk({serial_line_three_oe_o, serial_line_two_oe_o, serial_line_one_oe_o,
			serial_line_zero_oe_o}, 8'h0F);
		chk({serial_line_three_o, serial_line_two_o, serial_line_one_o,
			serial_line_zero_o}, 8'h0A);
		hw_reset_n_i = 1'b0;
		cyc(6);
		chk({in_reset_o, serial_line_three_oe_o, serial_line_one_oe_o}, 8'h04);
		hw_reset_n_i = 1'b1;
		h_frame = 1'b0;
		data_out_phase_i = 1'b0;
		cyc(8);
		chk({in_reset_o, serial_line_one_oe_o}, 8'h00);
	endtask
	// Pause: clock ignored, config disable, double rate cancels it
	task automatic s_pause;
		logic [7:0] n;
		n = 8'h00;
		cmd_class_i = `FSPR_CMD_NONE;
		h_drv = 4'hD;
		h_dat = 4'h5;
		h_frame = 1'b1;
		cyc(8);
		chk({paused_o, serial_line_one_oe_o}, 8'h02);
		repeat (24) begin
			cyc(1);
			if (rx_valid_o !== 1'b0) n++;
		end
		chk(n, 8'h00);
		persistent_config_reg_i = 8'hEF;
		cyc(8);
		chk(paused_o, 8'h00);
		persistent_config_reg_i = 8'hFF;
		cyc(8);
		pulse(dtr_seen_i);
		cyc(4);
		chk(paused_o, 8'h00);
		h_frame = 1'b0;
		h_dat = 4'hD;
		cyc(8);
		// Write guard low in the extended protocol blocks modify commands
		h_dat = 4'h9;
		cyc(5);
		chk(write_blocked_o, 8'h01);
		// Deselected four-line part: pause pin low resets the device
		proto_i = `FSPR_PROTO_FOUR;
		reset_capable_i = 1'b1;
		h_dat = 4'h5;
		cyc(5);
		chk(in_reset_o, 8'h01);
		h_dat = 4'hD;
		reset_capable_i = 1'b0;
		proto_i = `FSPR_PROTO_EXT;
		cyc(5);
	endtask
	// Boost: default off, enable by write, fast fallback, then timeout
	task automatic s_boost;
		chk(volatile_enh_config_reg_o, 8'hFF);
		proto_i = `FSPR_PROTO_FOUR;
		modify_op_i = 1'b1;
		pulse(last_data_i);
		cyc(3);
		chk(boost_active_o, 8'h00);
		volatile_enh_config_reg_wdata_i = 8'hF7;
		pulse(volatile_enh_config_reg_wr_i);
		cyc(1);
		chk(volatile_enh_config_reg_o, 8'hF7);
		pulse(last_data_i);
		cyc(3);
		chk(boost_active_o, 8'h01);
		boost_high_i = 1'b1;
		cyc(6);
		chk({boost_fast_o, eff_proto_o}, {5'h0, 1'b1, `FSPR_PROTO_EXT});
		boost_high_i = 1'b0;
		pulse(op_done_i);
		cyc(6);
		chk(eff_proto_o, {6'h0, `FSPR_PROTO_FOUR});
		pulse(last_data_i);
		cyc(60);
		chk({boost_active_o, boost_fast_o}, 8'h00);
		modify_op_i = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	initial begin
		#300000;
		miscompares++;
		end_sim();
	end
	initial begin
		{rst_i, ce_i, hw_reset_n_i} = 3'h7;
		{boost_high_i, data_out_phase_i, dtr_seen_i, modify_op_i, last_data_i} = 5'h00;
		{op_done_i, volatile_enh_config_reg_wr_i, pause_reset_dis_i, reset_capable_i, h_frame} = 5'h00;
		{proto_i, cmd_class_i, tx_bits_i, h_drv, h_dat} = 17'h0;
		persistent_config_reg_i = 8'hFF;
		volatile_enh_config_reg_wdata_i = 8'hFF;
		repeat (20) @(posedge clk_i);
		#5 rst_i = 1'b0;
		cyc(4);
		s_read();
		s_pause();
		s_boost();
		end_sim();
	end
endmodule // tb_top
`default_nettype wire
